// [pcs_regs.vh]
// Constants for the program counter, paging, return stack and indirect addressing block.
// Assumes inclusion by the design files of this block only.
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

`define PCS_ADDR_PTR        4'h0
`define PCS_ADDR_PAGE       4'h1
`define PCS_ADDR_PC         4'h2
`define PCS_ADDR_STK1       4'h3
`define PCS_ADDR_STK2       4'h4
`define PCS_ADDR_WORK       4'h5
`define PCS_ADDR_CFG        4'h6
`define PCS_INDIRECT_ADDR   5'h00
`define PCS_PAGE_PC_LSB     9
`define PCS_PAGE_WORD_BITS  9
`define PCS_PAGE_RESET      2'h0
`define PCS_PTR_RESET       7'h00
`define PCS_STATUS_PAGE_LO  5
`define PCS_STATUS_PAGE_HI  6
`define PCS_INDIRECT_ZERO   8'h00

`endif

// [pcs_ram.v]
// Data register file storage: 4 banks of 32 bytes, registered read data.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pcs_ram #(
   parameter AW = 7
) (
   input  wire          sys_clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [7:0]    wdata,
   input  wire [AW-1:0] raddr,
   output reg  [7:0]    rdata
);
   reg [7:0] mem [0:(1<<AW)-1];

   always @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // pcs_ram
`default_nettype wire

// [pcs_core.v]
// Program counter sequencing with paging, two-level return stack and indirect data port.
// Assumes decode pulses from the instruction decoder, one per instruction cycle.
// Contract
// - Page overflow on increment moves to next page; preselect bits unchanged.
// - Jump, call and low-byte write take page from preselect bits.
// - Reset loads program counter with all ones, the reset vector.
// - Reset clears page preselect bits, selecting page zero.
// - Two-entry return stack, each entry as wide as the counter.
// - Call moves entry one to two, then stores counter plus one.
// - Return loads counter from entry one, then copies entry two up.
// - Return-with-literal loads the working register with its literal.
// - Indirect port access goes to register addressed by the pointer.
// - Indirect read with pointer addressing the port returns zero.
// - Indirect write with pointer addressing the port changes nothing.
// - Pointer is five bits non-banked, seven bits banked.
// - Low five pointer bits select address within the 32-byte window.
// - Non-banked pointer bits six and five read as ones.
// - Banked pointer bits six and five select the data bank.
// - Jump supplies counter bits eight to zero from the instruction.
// - Call or low-byte write supplies bits seven to zero, clears bit eight.
// - Status page bits go to counter bits nine and ten on jump, call and low-byte write.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_regs.vh"
module pcs_core #(
   parameter PC_W   = 11,
   parameter BANKED = 1
) (
   input  wire            sys_clk,
   input  wire            nrst,
   input  wire            op_jump,
   input  wire            op_call,
   input  wire            op_retlit,
   input  wire            op_pcl_write,
   input  wire [8:0]      op_target,
   input  wire [7:0]      op_literal,
   input  wire            op_ptr_inc,
   input  wire            dat_wr,
   input  wire            dat_rd,
   input  wire [4:0]      dat_addr,
   input  wire [7:0]      dat_wdata,
   input  wire [3:0]      reg_addr,
   input  wire [7:0]      reg_wdata,
   input  wire            reg_wr,
   input  wire            reg_rd,
   output reg  [7:0]      reg_rdata,
   output reg  [PC_W-1:0] prog_addr,
   output reg  [7:0]      dat_rdata,
   output reg             dat_rvalid
);
   localparam PTR_W = BANKED ? 7 : 5;

   reg  [PC_W-1:0] pc_reg;
   reg  [PC_W-1:0] pc_next;
   reg  [PC_W-1:0] stk1_reg;
   reg  [PC_W-1:0] stk1_next;
   reg  [PC_W-1:0] stk2_reg;
   reg  [PC_W-1:0] stk2_next;
   reg  [1:0]      page_reg;
   reg  [6:0]      ptr_reg;
   reg  [6:0]      ptr_next;
   reg  [7:0]      work_reg;
   reg             self_rd_reg;
   reg             rd_pend_reg;
   wire [PC_W-1:0] pc_inc;
   wire [PC_W-1:0] pc_page_bits;
   wire [6:0]      ptr_view;
   wire            is_ind;
   wire [6:0]      eff_addr;
   wire            ram_we;
   wire [7:0]      ram_rdata;
   wire [6:0]      ptr_inc_val;

   // Plain binary increment carries into the page bits, crossing pages naturally
   assign pc_inc = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};

   // Upper counter bits come from preselect, never from the running page
   generate
      if (PC_W > 9) begin : g_page
         wire [1:0] pg = page_reg;
         assign pc_page_bits = {{(PC_W-9){1'b0}}, 9'h000} |
                               ({{(PC_W-2){1'b0}}, pg} << `PCS_PAGE_PC_LSB);
      end else begin : g_nopage
         assign pc_page_bits = {PC_W{1'b0}};
      end
   endgenerate

   // Unimplemented bank bits read as ones on the non-banked variant
   assign ptr_view = BANKED ? ptr_reg : {2'b11, ptr_reg[4:0]};
   assign is_ind   = (dat_addr == `PCS_INDIRECT_ADDR);
   // Bank bits pick the bank; low five select within the window
   assign eff_addr = is_ind ? (BANKED ? ptr_reg : {2'b00, ptr_reg[4:0]})
                            : {(BANKED ? ptr_reg[6:5] : 2'b00), dat_addr};
   // Pointer addressing the port itself makes the write a no-operation
   assign ram_we   = dat_wr && !(is_ind && ptr_reg[4:0] == `PCS_INDIRECT_ADDR);
   // Non-banked sum stays five bits so the carry never reaches the bank bits
   assign ptr_inc_val = BANKED ? ptr_reg + 7'h01
                               : {2'b00, ptr_reg[4:0] + 5'h01};

   always @* begin
      pc_next   = pc_inc;
      stk1_next = stk1_reg;
      stk2_next = stk2_reg;
      if (op_jump) begin
         pc_next = pc_page_bits | {{(PC_W-9){1'b0}}, op_target};
      end else if (op_call) begin
         stk2_next = stk1_reg;
         stk1_next = pc_inc;
         pc_next   = pc_page_bits | {{(PC_W-8){1'b0}}, op_target[7:0]};
      end else if (op_pcl_write) begin
         pc_next = pc_page_bits | {{(PC_W-8){1'b0}}, dat_wdata};
      end else if (op_retlit) begin
         pc_next   = stk1_reg;
         stk1_next = stk2_reg;
      end
   end

   always @* begin
      ptr_next = ptr_reg;
      if (reg_wr && reg_addr == `PCS_ADDR_PTR) begin
         ptr_next = BANKED ? reg_wdata[6:0] : {2'b00, reg_wdata[4:0]};
      end else if (op_ptr_inc) begin
         ptr_next = ptr_inc_val;
      end
   end

   always @(posedge sys_clk) begin
      if (!nrst) begin
         pc_reg      <= {PC_W{1'b1}};
         prog_addr   <= {PC_W{1'b1}};
         page_reg    <= `PCS_PAGE_RESET;
         stk1_reg    <= {PC_W{1'b0}};
         stk2_reg    <= {PC_W{1'b0}};
         ptr_reg     <= `PCS_PTR_RESET;
         work_reg    <= 8'h00;
         self_rd_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         dat_rdata   <= 8'h00;
         dat_rvalid  <= 1'b0;
         reg_rdata   <= 8'h00;
      end else begin
         pc_reg      <= pc_next;
         prog_addr   <= pc_next;
         stk1_reg    <= stk1_next;
         stk2_reg    <= stk2_next;
         ptr_reg     <= ptr_next;
         self_rd_reg <= is_ind && ptr_reg[4:0] == `PCS_INDIRECT_ADDR;
         rd_pend_reg <= dat_rd;
         dat_rvalid  <= rd_pend_reg;
         // Self-addressed indirect read yields zero, not stale storage
         dat_rdata   <= self_rd_reg ? `PCS_INDIRECT_ZERO : ram_rdata;
         if (op_retlit) begin
            work_reg <= op_literal;
         end else if (reg_wr && reg_addr == `PCS_ADDR_WORK) begin
            work_reg <= reg_wdata;
         end
         // Preselect only changes by software; increments never touch it
         if (reg_wr && reg_addr == `PCS_ADDR_PAGE) begin
            page_reg <= reg_wdata[`PCS_STATUS_PAGE_HI:`PCS_STATUS_PAGE_LO];
         end
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            if (reg_addr == `PCS_ADDR_PTR) begin
               reg_rdata <= {1'b0, ptr_view};
            end else if (reg_addr == `PCS_ADDR_PAGE) begin
               reg_rdata <= {1'b0, page_reg, 5'h00};
            end else if (reg_addr == `PCS_ADDR_PC) begin
               reg_rdata <= pc_reg[7:0];
            end else if (reg_addr == `PCS_ADDR_STK1) begin
               reg_rdata <= stk1_reg[7:0];
            end else if (reg_addr == `PCS_ADDR_STK2) begin
               reg_rdata <= stk2_reg[7:0];
            end else if (reg_addr == `PCS_ADDR_WORK) begin
               reg_rdata <= work_reg;
            end else if (reg_addr == `PCS_ADDR_CFG) begin
               reg_rdata <= (BANKED != 0) ? 8'h01 : 8'h00;
            end else begin
               reg_rdata <= 8'h00;
            end
         end
      end
   end

   pcs_ram #(
      .AW (7)
   ) u_ram (
      .sys_clk (sys_clk),
      .we      (ram_we),
      .waddr   (eff_addr),
      .wdata   (dat_wdata),
      .raddr   (eff_addr),
      .rdata   (ram_rdata)
   );
endmodule // pcs_core
`default_nettype wire

// [pcs_decode_model.sv]
// Instruction decoder stand-in: one command code becomes one op pulse.
// Assumes the bench steps the code once per instruction cycle.
`timescale 1ns/100ps
`default_nettype none
module pcs_decode_model (
   input  wire logic [2:0] cmd,
   output logic            op_jump,
   output logic            op_call,
   output logic            op_pcl_write,
   output logic            op_retlit,
   output logic            op_ptr_inc
);
   // A single code can never raise two ops at once
   assign op_jump = (cmd == 3'h1);
   assign op_call = (cmd == 3'h2);
   assign op_pcl_write = (cmd == 3'h3);
   assign op_retlit = (cmd == 3'h4);
   assign op_ptr_inc = (cmd == 3'h5);
endmodule // pcs_decode_model
`default_nettype wire

// [pcs_core_checker.sv]
// Properties on the program counter block ports.
// Assumes a bind onto pcs_core; page and literal mirrored from inputs.
`timescale 1ns/100ps
`default_nettype none
module pcs_core_checker #(parameter PC_W = 11) (
   input wire logic            sys_clk,
   input wire logic            nrst,
   input wire logic            op_jump,
   input wire logic            op_call,
   input wire logic            op_retlit,
   input wire logic            op_pcl_write,
   input wire logic [8:0]      op_target,
   input wire logic [7:0]      op_literal,
   input wire logic            dat_rd,
   input wire logic [3:0]      reg_addr,
   input wire logic [7:0]      reg_wdata,
   input wire logic            reg_wr,
   input wire logic            reg_rd,
   input wire logic [7:0]      reg_rdata,
   input wire logic [PC_W-1:0] prog_addr,
   input wire logic            dat_rvalid
);
   logic [1:0] page_reg;
   logic [7:0] work_reg;
   wire  [PC_W-1:0] one_w = {{(PC_W-1){1'b0}}, 1'b1};
   always @(posedge sys_clk) begin
      if (!nrst)
         page_reg <= 2'h0;
      else if (reg_wr && reg_addr == 4'h1)
         page_reg <= reg_wdata[6:5];
      if (!nrst)
         work_reg <= 8'h00;
      else if (op_retlit)
         work_reg <= op_literal;
      else if (reg_wr && reg_addr == 4'h5)
         work_reg <= reg_wdata;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_reset_vec: assert property (disable iff (1'b0) !nrst |=> &prog_addr)
      else $error("pc not at reset vector");
   a_page_load: assert property ((op_jump || op_call || op_pcl_write) |=>
      prog_addr[PC_W-1:9] == $past(page_reg[PC_W-10:0])) else $error("page bits wrong");
   a_jump_low: assert property (op_jump |=> prog_addr[8:0] == $past(op_target))
      else $error("jump low bits wrong");
   a_call_low: assert property (op_call |=>
      prog_addr[8:0] == {1'b0, $past(op_target[7:0])}) else $error("call low bits wrong");
   a_pc_step: assert property (!(op_jump || op_call || op_pcl_write || op_retlit) |=>
      prog_addr == $past(prog_addr) + one_w) else $error("pc did not step");
   a_call_ret: assert property (op_call ##1 op_retlit |=>
      prog_addr == $past(prog_addr, 2) + one_w) else $error("return address wrong");
   a_work_lit: assert property ((reg_rd && reg_addr == 4'h5) |=>
      reg_rdata == $past(work_reg)) else $error("working value wrong");
   a_rd_valid: assert property (dat_rd |-> ##2 dat_rvalid)
      else $error("data read not answered");
endmodule // pcs_core_checker
`default_nettype wire

// [pcs_core_bench.sv]
// Self-checking bench for pcs_core with the decoder stand-in.
// Assumes the banked 11-bit variant; page writes go via register 1.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module pcs_core_bench;
   logic        sys_clk = 0, nrst = 0, dat_wr = 0, dat_rd = 0, reg_wr = 0, reg_rd = 0;
   logic [2:0]  cmd = 0;
   logic [8:0]  op_target = 0;
   logic [4:0]  dat_addr = 0;
   logic [7:0]  dat_wdata = 0, reg_wdata = 0, reg_rdata, dat_rdata;
   logic [3:0]  reg_addr = 0;
   logic [10:0] prog_addr;
   logic [22:0] rows [10];
   wire         op_jump, op_call, op_pcl_write, op_retlit, op_ptr_inc, dat_rvalid;
   wire  [7:0]  op_literal = op_target[7:0];
   int          num_errors = 0, checks = 0;
   pcs_decode_model dec (.cmd, .op_jump, .op_call, .op_pcl_write, .op_retlit, .op_ptr_inc);
   pcs_core dut (.sys_clk, .nrst, .op_jump, .op_call, .op_retlit, .op_pcl_write, .op_target,
      .op_literal, .op_ptr_inc, .dat_wr, .dat_rd, .dat_addr, .dat_wdata, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prog_addr, .dat_rdata, .dat_rvalid);
   always #25 sys_clk = ~sys_clk;
   task automatic tally_and_finish;
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input [3:0] a, input [7:0] d, input r);
      @(posedge sys_clk);
      reg_wr <= !r;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 if (r) `CHK(reg_rdata, d)
   endtask
   task automatic dat(input w, input [4:0] a, input [7:0] d);
      @(posedge sys_clk);
      dat_wr <= w;
      dat_rd <= !w;
      dat_addr <= a;
      dat_wdata <= d;
      @(posedge sys_clk);
      dat_wr <= 1'b0;
      dat_rd <= 1'b0;
      @(posedge sys_clk);
      #1 if (!w) `CHK({dat_rvalid, dat_rdata}, {1'b1, d})
   endtask
   task automatic op(input [2:0] c, input [8:0] a);
      @(posedge sys_clk);
      cmd <= c;
      op_target <= a;
      dat_wdata <= a[7:0];
      @(posedge sys_clk);
      cmd <= 3'h0;
   endtask
   initial begin
      // Three calls overflow the two-entry stack, so later returns repeat
      rows = '{{3'h1, 9'h1ff, 11'h1ff}, {3'h0, 9'h0, 11'h200}, {3'h1, 9'h005, 11'h005},
         {3'h2, 9'h1ab, 11'h0ab}, {3'h2, 9'h010, 11'h010}, {3'h2, 9'h020, 11'h020},
         {3'h4, 9'h0a5, 11'h011}, {3'h4, 9'h000, 11'h0ac}, {3'h4, 9'h03c, 11'h0ac},
         {3'h0, 9'h0, 11'h0ad}};
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         cmd <= rows[i][22:20];
         op_target <= rows[i][19:11];
         if (i > 0) #1 `CHK(prog_addr, rows[i-1][10:0])
      end
      @(posedge sys_clk);
      #1 `CHK(prog_addr, rows[9][10:0])
      wr(4'h1, 8'h60, 0);
      op(3'h1, 9'h123);
      #1 `CHK(prog_addr, 11'h723)
      op(3'h3, 9'h19c);
      #1 `CHK(prog_addr, 11'h69c)
      wr(4'h5, 8'h3c, 1);
      wr(4'h6, 8'h01, 1);
      wr(4'hf, 8'h00, 1);
      wr(4'h0, 8'h28, 0);
      dat(1, 5'h08, 8'h10);
      dat(0, 5'h00, 8'h10);
      op(3'h5, 9'h0);
      wr(4'h0, 8'h29, 1);
      wr(4'h0, 8'h00, 0);
      dat(1, 5'h00, 8'h55);
      dat(0, 5'h00, 8'h00);
      wr(4'h0, 8'h7f, 0);
      op(3'h5, 9'h0);
      wr(4'h0, 8'h00, 1);
      @(posedge sys_clk);
      nrst <= 1'b0;
      @(posedge sys_clk);
      nrst <= 1'b1;
      #1 `CHK(prog_addr, 11'h7ff)
      wr(4'h1, 8'h00, 1);
      tally_and_finish;
   end
   initial begin
      #20000;
      num_errors++;
      tally_and_finish;
   end
endmodule // pcs_core_bench
bind pcs_core pcs_core_checker #(.PC_W(PC_W)) chk (.sys_clk, .nrst, .op_jump, .op_call,
   .op_retlit, .op_pcl_write, .op_target, .op_literal, .dat_rd, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .prog_addr, .dat_rvalid);
`default_nettype wire
